/* File: bundle_crossing.sv */
// Toggle handshake that carries one settings bundle between clock domains
`timescale 1ns/1ps
`default_nettype none
module bundle_crossing (
    input  wire logic                            src_clk,
    input  wire logic                            src_rst_n,
    input  wire logic                            send,
    input  wire logic [pull_ctrl_pkg::BUNDLE_W-1:0] src_data,
    output logic                                 busy,
    input  wire logic                            dst_clk,
    input  wire logic                            dst_rst_n,
    input  wire logic                            take,
    output logic                                 dst_valid,
    output logic [pull_ctrl_pkg::BUNDLE_W-1:0]   dst_data
);
    import pull_ctrl_pkg::*;

    logic [BUNDLE_W-1:0] hold_q, hold_d;
    logic                req_q, req_d;
    logic                ack_s1_q, ack_s2_q;
    logic                req_s1_q, req_s2_q;
    logic                seen_q, seen_d;
    logic                valid_d;
    logic [BUNDLE_W-1:0] out_d;

    // Source side: hold the bundle steady until the ack returns
    always_comb begin
        hold_d = hold_q;
        req_d  = req_q;
        if (send && !busy) begin
            hold_d = src_data;
            req_d  = !req_q;
        end
    end

    always_ff @(posedge src_clk) begin
        if (!src_rst_n) begin
            hold_q   <= '0;
            req_q    <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            hold_q   <= hold_d;
            req_q    <= req_d;
            ack_s1_q <= seen_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    assign busy = (req_q != ack_s2_q);

    // Destination side: capture only when the consumer allows it
    always_comb begin
        seen_d  = seen_q;
        valid_d = 1'b0;
        out_d   = dst_data;
        if ((req_s2_q != seen_q) && take) begin
            seen_d  = req_s2_q;
            valid_d = 1'b1;
            out_d   = hold_q; // Stable while the request is open
        end
    end

    always_ff @(posedge dst_clk) begin
        if (!dst_rst_n) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            seen_q    <= 1'b0;
            dst_valid <= 1'b0;
            dst_data  <= '0;
        end else begin
            req_s1_q  <= req_q;
            req_s2_q  <= req_s1_q;
            seen_q    <= seen_d;
            dst_valid <= valid_d;
            dst_data  <= out_d;
        end
    end
endmodule
`default_nettype wire

/* File: digital_frequency_pull_control_tb.sv */
// Self-checking bench for the frequency pull control block
`timescale 1ns/1ps
`default_nettype none
module digital_frequency_pull_control_tb;
    import pull_ctrl_pkg::*;
    logic        core_clk      = 1'b0;
    logic        link_clk      = 1'b0;
    logic        rst_n         = 1'b0;
    logic        link_rst_n    = 1'b0;
    logic [3:0]  factory_range = 4'h0;
    logic        oe_hw_select  = 1'b0;
    logic        oe_pin        = 1'b0;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [15:0] wr_data;
    logic [7:0]  rd_addr;
    logic [15:0] rd_data;
    logic [25:0] offset_word;
    logic [3:0]  pull_range;
    logic [2:0]  step_class;
    logic        out_enable;
    logic        update_pulse;
    // Reference model of the register contents
    logic [15:0] low_m         = 16'h0000;
    logic [9:0]  high_m        = 10'h000;
    logic        oe_m          = 1'b0;
    logic [3:0]  rng_m         = 4'h0;
    int          n_errors      = 0;
    int          comparisons   = 0;
    int          cyc           = 0;
    int          last_pulse    = -1;
    logic [25:0] words[$];

    // Clocks: 50 ns core, 12 ns link; their rising edges never coincide
    always #25 core_clk = ~core_clk;
    always #6 link_clk = ~link_clk;

    freq_pull_ctrl i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
        .link_rst_n(link_rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
        .factory_range(factory_range), .oe_hw_select(oe_hw_select),
        .oe_pin(oe_pin), .offset_word(offset_word),
        .pull_range(pull_range), .step_class(step_class),
        .out_enable(out_enable), .update_pulse(update_pulse)
    );

    host_model i_host (
        .link_clk(link_clk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Every applied update must keep the pacing gap
    always @(posedge core_clk) begin
        cyc++;
        if (update_pulse === 1'b1) begin
            if (last_pulse >= 0) begin
                check(32'(cyc - last_pulse >= UPDATE_GAP_CYC), 32'h1);
            end
            last_pulse = cyc;
        end
    end

    // Register write, mirrored into the model
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_host.write(a, d);
        case (a)
            ADDR_LOW_WORD: low_m = d;
            ADDR_HIGH_WORD: begin
                high_m = d[9:0];
                if (oe_hw_select == 1'b0) begin
                    oe_m = d[10];
                end
            end
            ADDR_RANGE: rng_m = d[3:0];
            default: ;
        endcase
    endtask

    // Low word first, high word with enable kept on
    task automatic set_word(input logic [25:0] w);
        wr(ADDR_LOW_WORD, w[15:0]);
        wr(ADDR_HIGH_WORD, {5'h00, 1'b1, w[25:16]});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.read(a, d);
        check(32'(d), 32'(exp));
    endtask

    task automatic regs_chk();
        rd_chk(ADDR_LOW_WORD, low_m);
        rd_chk(ADDR_HIGH_WORD, {5'h00, oe_m, high_m});
        rd_chk(ADDR_RANGE, {12'h000, rng_m});
        rd_chk(8'h03, 16'h0000);
    endtask

    // Wait for the next update and compare all applied settings
    task automatic wait_pulse();
        int          n;
        logic [25:0] w;
        n = 0;
        w = {high_m, low_m};
        if (w == MOST_NEG) begin
            w = NEG_LIMIT;
        end
        do begin
            @(posedge core_clk);
            n++;
        end while (update_pulse !== 1'b1 && n < 2000);
        check(32'(n < 2000), 32'h1);
        check(32'(offset_word), 32'(w));
        check(32'(pull_range), 32'(rng_m));
        check(32'(step_class),
              32'((rng_m > FINE_RANGE_MAX) ? rng_m - 4'h9 : 4'h0));
        repeat (4) @(posedge core_clk);
        check(32'(out_enable), 32'(oe_hw_select ? oe_pin : oe_m));
    endtask

    // Main sequence
    initial begin
        int n;
        void'($urandom(87));
        @(posedge core_clk);
        factory_range <= 4'($urandom);
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge link_clk);
        link_rst_n <= 1'b1;
        rng_m = factory_range;
        wait_pulse();
        regs_chk();
        $display("test reset values done");

        wr(ADDR_LOW_WORD, 16'($urandom));
        n = 0;
        repeat (600) @(posedge core_clk) n += int'(update_pulse === 1'b1);
        check(32'(n), 32'h0);
        check(32'(offset_word), 32'h0);
        regs_chk();
        $display("test low word only done");

        wr(ADDR_HIGH_WORD, {5'h1F, 1'b1, 10'($urandom)});
        wait_pulse();
        regs_chk();
        $display("test high word done");

        for (int i = 0; i < 16; i++) begin
            wr(ADDR_RANGE, {12'($urandom), 4'(i)});
            wait_pulse();
            rd_chk(ADDR_RANGE, {12'h000, rng_m});
        end
        $display("test range codes done");

        wr(ADDR_RANGE, 16'h0009);
        wait_pulse();
        words = {FULL_SCALE, MOST_NEG,
                 26'((64'd33554431 * 180 + 200) / 400),
                 26'($urandom), 26'($urandom)};
        foreach (words[i]) begin
            set_word(words[i]);
            wait_pulse();
        end
        check(32'(words[2]), 32'h0E66666);
        $display("test offset words done");

        @(posedge core_clk);
        oe_hw_select <= 1'b1;
        oe_pin       <= 1'b1;
        // Pin select needs two flops in the link domain before the write
        repeat (2) @(posedge core_clk);
        wr(ADDR_HIGH_WORD, {5'h00, ~oe_m, high_m});
        wait_pulse();
        regs_chk();
        @(posedge core_clk);
        oe_pin <= 1'b0;
        repeat (5) @(posedge core_clk);
        check(32'(out_enable), 32'h0);
        $display("test hardware enable done");
        finish_test();
    end

    // Watchdog well beyond the paced run length
    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire

/* File: freq_pull_ctrl.sv */
// Digital frequency pull control registers with paced offset updates
//
// Operation
// R1: After reset, zero offset and factory pull range are in use.
// R2: Host writes change pull range and frequency offset after reset.
// R3: Applied offset never exceeds the selected pull range edge.
// R4: Four-bit field at 0x02[3:0] selects one of sixteen ranges.
// R5: Step class is finest up to 200 ppm, coarser above.
// R6: Offset is a 26-bit two's complement word.
// R7: All offset bits reset to zero.
// R8: Low word at 0x00[15:0], high ten bits at 0x01[9:0].
// R9: Low word write alone never changes the applied offset.
// R10: Host should write low word before high word.
// R11: Word 33,554,431 is the positive range edge.
// R12: Output enable bit 0x01[10] ignored under hardware pin control.
// R13: Software enable bit 0 disables output, 1 enables; resets to 0.
// R14: Host writes enable bit 1 with high word to stay on.
// R15: Offset updates applied no faster than 38 kHz.
// R16: Unused upper bits of 0x01 and 0x02 read zero, writes ignored.
// R17: Pull range loads factory value after reset, host may overwrite.
// R18: High word write moves low and high words in together.
`timescale 1ns/1ps
`default_nettype none
module freq_pull_ctrl (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire logic                              link_clk,
    input  wire logic                              link_rst_n,
    input  wire logic                              wr_en,
    input  wire logic [7:0]                        wr_addr,
    input  wire logic [pull_ctrl_pkg::REG_W-1:0]   wr_data,
    input  wire logic [7:0]                        rd_addr,
    output logic [pull_ctrl_pkg::REG_W-1:0]        rd_data,
    input  wire logic [pull_ctrl_pkg::RANGE_W-1:0] factory_range,
    input  wire logic                              oe_hw_select,
    input  wire logic                              oe_pin,
    output logic [pull_ctrl_pkg::OFFSET_W-1:0]     offset_word,
    output logic [pull_ctrl_pkg::RANGE_W-1:0]      pull_range,
    output logic [pull_ctrl_pkg::STEP_W-1:0]       step_class,
    output logic                                   out_enable,
    output logic                                   update_pulse
);
    import pull_ctrl_pkg::*;

    // Link domain state
    logic [LOW_W-1:0]    low_q, low_d;
    logic [OFFSET_W-1:0] word_q, word_d; // R6
    logic                oe_q, oe_d;
    logic [RANGE_W-1:0]  range_q, range_d;
    logic                pend_q, pend_d;
    logic                send;
    logic [1:0]          strap_cnt_q, strap_cnt_d;
    logic [REG_W-1:0]    rd_d;
    logic [RANGE_W-1:0]  strap_s1_q, strap_s2_q;
    logic                hw_l1_q, hw_l2_q;
    logic                busy;

    // Core domain state
    logic                dst_valid;
    logic [BUNDLE_W-1:0] dst_data;
    logic                take;
    pace_state_type      pace_q, pace_d;
    logic [GAP_W-1:0]    gap_q, gap_d;
    logic [OFFSET_W-1:0] offset_d;
    logic [RANGE_W-1:0]  prange_d;
    logic [STEP_W-1:0]   step_d;
    logic                sw_oe_q, sw_oe_d;
    logic                update_d;
    logic                oe_out_d;
    logic                hw_c1_q, hw_c2_q;
    logic                pin_c1_q, pin_c2_q;
    logic                b_oe;
    logic [RANGE_W-1:0]  b_range;
    logic [OFFSET_W-1:0] b_word;

    // Pins reaching the link domain pass two flops first
    always_ff @(posedge link_clk) begin
        strap_s1_q <= factory_range;
        strap_s2_q <= strap_s1_q;
        hw_l1_q    <= oe_hw_select;
        hw_l2_q    <= hw_l1_q;
    end

    // Register writes, factory strap load and bundle launch
    always_comb begin
        low_d       = low_q;
        word_d      = word_q;
        oe_d        = oe_q;
        range_d     = range_q;
        pend_d      = pend_q;
        strap_cnt_d = strap_cnt_q;
        send        = 1'b0;
        if (pend_q && !busy) begin
            send   = 1'b1;
            pend_d = 1'b0;
        end
        if (strap_cnt_q != STRAP_DONE_CNT) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
        end
        if (strap_cnt_q == STRAP_LOAD_CNT) begin
            range_d = strap_s2_q; // R17
            pend_d  = 1'b1;       // R1
        end
        if (wr_en) begin
            unique case (wr_addr)
                ADDR_LOW_WORD: begin
                    low_d = wr_data; // R9
                end
                ADDR_HIGH_WORD: begin
                    word_d = {wr_data[HIGH_W-1:0], low_q}; // R8 R18
                    if (!hw_l2_q) begin
                        oe_d = wr_data[OE_BIT]; // R12
                    end
                    pend_d = 1'b1; // R2
                end
                ADDR_RANGE: begin
                    range_d = wr_data[RANGE_W-1:0]; // R4
                    pend_d  = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unused upper bits and holes read zero
    always_comb begin
        unique case (rd_addr)
            ADDR_LOW_WORD:  rd_d = low_q;
            ADDR_HIGH_WORD: rd_d = {5'h00, oe_q, word_q[OFFSET_W-1:LOW_W]}; // R16
            ADDR_RANGE:     rd_d = {12'h000, range_q}; // R16
            default:        rd_d = 16'h0000;
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            low_q       <= OFFSET_RESET[LOW_W-1:0];
            word_q      <= OFFSET_RESET; // R7
            oe_q        <= OE_RESET;     // R13
            range_q     <= RANGE_RESET;
            pend_q      <= 1'b0;
            strap_cnt_q <= 2'h0;
            rd_data     <= 16'h0000;
        end else begin
            low_q       <= low_d;
            word_q      <= word_d;
            oe_q        <= oe_d;
            range_q     <= range_d;
            pend_q      <= pend_d;
            strap_cnt_q <= strap_cnt_d;
            rd_data     <= rd_d;
        end
    end

    // Settings cross as one bundle so words never mix
    bundle_crossing u_cross (
        .src_clk   (link_clk),
        .src_rst_n (link_rst_n),
        .send      (send),
        .src_data  ({oe_q, range_q, word_q}),
        .busy      (busy),
        .dst_clk   (core_clk),
        .dst_rst_n (rst_n),
        .take      (take),
        .dst_valid (dst_valid),
        .dst_data  (dst_data)
    );

    assign b_oe    = dst_data[BUNDLE_W-1];
    assign b_range = dst_data[OFFSET_W +: RANGE_W];
    assign b_word  = dst_data[OFFSET_W-1:0];

    // Enable pins enter the core domain through two flops
    always_ff @(posedge core_clk) begin
        hw_c1_q  <= oe_hw_select;
        hw_c2_q  <= hw_c1_q;
        pin_c1_q <= oe_pin;
        pin_c2_q <= pin_c1_q;
    end

    // Pacing holds the next bundle back until the gap expires
    assign take = (pace_q == PACE_READY) && !dst_valid; // R15

    always_comb begin
        pace_d   = pace_q;
        gap_d    = gap_q;
        offset_d = offset_word;
        prange_d = pull_range;
        step_d   = step_class;
        sw_oe_d  = sw_oe_q;
        update_d = 1'b0;
        unique case (pace_q)
            PACE_READY: begin
                if (dst_valid) begin
                    // Most negative code would sit one step past the edge
                    offset_d = (b_word == MOST_NEG) ? NEG_LIMIT : b_word; // R3 R11
                    prange_d = b_range; // R4
                    // Coarser steps only above the finest ranges
                    step_d   = (b_range <= FINE_RANGE_MAX) ? 3'h0 :
                               STEP_W'(b_range - FINE_RANGE_MAX); // R5
                    sw_oe_d  = b_oe;
                    update_d = 1'b1;
                    pace_d   = PACE_GAP;
                    gap_d    = GAP_LOAD; // R15
                end
            end
            PACE_GAP: begin
                if (gap_q == '0) begin
                    pace_d = PACE_READY;
                end else begin
                    gap_d = gap_q - 10'h001;
                end
            end
            default: begin
                pace_d = PACE_READY; // Unused codes fall back to idle
            end
        endcase
    end

    // Hardware pin wins when the output is under pin control
    assign oe_out_d = hw_c2_q ? pin_c2_q : sw_oe_q; // R12 R13

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pace_q       <= PACE_READY;
            gap_q        <= '0;
            offset_word  <= OFFSET_RESET; // R7 R1
            pull_range   <= RANGE_RESET;
            step_class   <= 3'h0;
            sw_oe_q      <= OE_RESET;
            update_pulse <= 1'b0;
            out_enable   <= 1'b0;
        end else begin
            pace_q       <= pace_d;
            gap_q        <= gap_d;
            offset_word  <= offset_d;
            pull_range   <= prange_d;
            step_class   <= step_d;
            sw_oe_q      <= sw_oe_d;
            update_pulse <= update_d;
            out_enable   <= oe_out_d;
        end
    end

    // Helper: cycles since the last applied update, saturating
    logic [GAP_W:0] since_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            since_q <= '1;
        end else if (update_pulse) begin
            since_q <= '0;
        end else if (since_q != '1) begin
            since_q <= since_q + 11'h001;
        end
    end

    sequence s_apply;
        dst_valid ##1 update_pulse;
    endsequence

    a_offset_reset: assert property (@(posedge core_clk) // R7
        !rst_n |=> offset_word == OFFSET_RESET && !update_pulse)
        else $error("offset not cleared by reset");

    a_offset_bounds: assert property (@(posedge core_clk) // R3
        disable iff (!rst_n) offset_word != MOST_NEG)
        else $error("offset beyond range edge");

    a_update_spacing: assert property (@(posedge core_clk) // R15
        disable iff (!rst_n) update_pulse |-> since_q >= 11'h20E)
        else $error("updates closer than pacing gap");

    a_offset_only_update: assert property (@(posedge core_clk) // R9
        disable iff (!rst_n) $changed(offset_word) |-> update_pulse)
        else $error("offset changed without an update");

    a_apply_word: assert property (@(posedge core_clk) // R18
        disable iff (!rst_n)
        s_apply |-> offset_word == (($past(b_word) == MOST_NEG) ?
                                    NEG_LIMIT : $past(b_word)))
        else $error("applied word differs from bundle");

    a_apply_follows: assert property (@(posedge core_clk) // R2
        disable iff (!rst_n) update_pulse |-> $past(dst_valid))
        else $error("update without a delivered bundle");

    a_step_class: assert property (@(posedge core_clk) // R5
        disable iff (!rst_n)
        update_pulse |-> (pull_range <= FINE_RANGE_MAX) ?
            step_class == 3'h0 :
            step_class == 3'(pull_range - FINE_RANGE_MAX))
        else $error("step class does not match range");

    a_sw_enable: assert property (@(posedge core_clk) // R13
        disable iff (!rst_n)
        !hw_c2_q ##1 !hw_c2_q |-> out_enable == $past(sw_oe_q))
        else $error("output enable ignores software bit");

    a_gap_blocks: assert property (@(posedge core_clk) // R15
        disable iff (!rst_n) update_pulse |-> !take [*8])
        else $error("bundle accepted during pacing gap");

    a_oe_write_ignored: assert property (@(posedge link_clk) // R12
        disable iff (!link_rst_n)
        wr_en && wr_addr == ADDR_HIGH_WORD && hw_l2_q |=> $stable(oe_q))
        else $error("enable bit written under pin control");

    a_low_write_quiet: assert property (@(posedge link_clk) // R9
        disable iff (!link_rst_n)
        wr_en && wr_addr == ADDR_LOW_WORD |=> $stable(word_q))
        else $error("low word write moved the offset");
endmodule
`default_nettype wire

/* File: host_model.sv */
// Host model that writes and reads the pull control registers
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        link_clk,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [15:0]      wr_data,
    output logic [7:0]       rd_addr,
    input  wire logic [15:0] rd_data
);
    // Idle bus levels before the first transfer
    initial begin
        wr_en   = 1'b0;
        wr_addr = 8'h00;
        wr_data = 16'h0000;
        rd_addr = 8'h00;
    end

    // One strobe cycle; afterwards address and data are scrambled
    // so a design that samples late sees garbage, not the last value
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(posedge link_clk);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge link_clk);
        wr_en   <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask

    // Read data is registered, so it is taken on the second edge
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(posedge link_clk);
        rd_addr <= a;
        @(posedge link_clk);
        @(posedge link_clk);
        d = rd_data;
    endtask
endmodule
`default_nettype wire

/* File: pull_ctrl_pkg.sv */
// Constants and types shared by the frequency pull control block
`default_nettype none
package pull_ctrl_pkg;
    // Register addresses
    localparam logic [7:0]  ADDR_LOW_WORD   = 8'h00;
    localparam logic [7:0]  ADDR_HIGH_WORD  = 8'h01;
    localparam logic [7:0]  ADDR_RANGE      = 8'h02;
    // Field widths and positions
    localparam int          REG_W           = 16;
    localparam int          OFFSET_W        = 26;
    localparam int          LOW_W           = 16;
    localparam int          HIGH_W          = 10;
    localparam int          RANGE_W         = 4;
    localparam int          OE_BIT          = 10;
    localparam int          STEP_W          = 3;
    localparam int          BUNDLE_W        = OFFSET_W + RANGE_W + 1;
    // Reset values
    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 26'h0000000;
    localparam logic        OE_RESET        = 1'b0;
    localparam logic [RANGE_W-1:0]  RANGE_RESET  = 4'h0;
    // Full scale word is the positive edge of the range
    localparam logic [OFFSET_W-1:0] FULL_SCALE   = 26'h1FFFFFF;
    localparam logic [OFFSET_W-1:0] MOST_NEG     = 26'h2000000;
    localparam logic [OFFSET_W-1:0] NEG_LIMIT    = 26'h2000001;
    // Highest range code that still has the finest step
    localparam logic [RANGE_W-1:0]  FINE_RANGE_MAX = 4'h9;
    // Update pacing
    localparam int          CORE_CLK_HZ     = 20_000_000;
    localparam int          UPDATE_RATE_HZ  = 38_000;
    localparam int          UPDATE_GAP_CYC  =
        (CORE_CLK_HZ + UPDATE_RATE_HZ - 1) / UPDATE_RATE_HZ;
    localparam int          GAP_W           = 10;
    localparam logic [GAP_W-1:0] GAP_LOAD   = GAP_W'(UPDATE_GAP_CYC - 2);
    // Strap capture happens on this count after link reset release
    localparam logic [1:0]  STRAP_LOAD_CNT  = 2'h1;
    localparam logic [1:0]  STRAP_DONE_CNT  = 2'h2;

    // Update pacing states, Gray coded
    typedef enum logic [1:0] {
        PACE_READY = 2'b00,
        PACE_GAP   = 2'b01
    } pace_state_type;
endpackage
`default_nettype wire
